// ==== rtl/ptb_ctrl.sv ====
// pwm primary time base with its control register, on an ahb-lite slave
// assumes cpu_idle and irq_ack come from logic on hclk; sync pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
module ptb_ctrl
   import ptb_pkg::*;
#(
   parameter int SRC_N = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // system side
   input wire logic cpu_idle,
   input wire logic irq_ack,
   output logic special_event_irq,
   output logic pwm_run,
   // sync pins
   input wire logic [SRC_N-1:0] sync_in_pin,
   output logic sync_out_pin
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // ---------------------------------------------------------------
   // bus slave: one wait state, so hrdata comes from a flop
   // ---------------------------------------------------------------
   ptb_bus_e state, next_state;
   logic [7:0] addr_q, next_addr_q;
   logic write_q, next_write_q;
   logic next_hreadyout;
   logic [31:0] next_hrdata;
   logic wr_ctrl, wr_period, wr_cmp;

   logic [15:0] ctrl, next_ctrl;
   logic [15:0] period_buf, next_period_buf;
   logic [15:0] active_period, next_active_period;
   logic [15:0] sevt_cmp, next_sevt_cmp;
   logic [15:0] count, next_count;

   always_comb begin
      next_state = state;
      next_addr_q = addr_q;
      next_write_q = write_q;
      next_hreadyout = 1'b1;
      next_hrdata = hrdata;
      if (state == PTB_BUS_IDLE) begin
         if (hsel && htrans[1] && hready) begin
            next_state = PTB_BUS_ACC;
            next_addr_q = haddr[7:0];
            next_write_q = hwrite;
            next_hreadyout = 1'b0;
         end
      end else begin
         next_state = PTB_BUS_IDLE;
         next_hrdata = 32'h0000_0000;
         if (!write_q) begin
            if (hit(addr_q, PTB_OFF_CTRL))
               next_hrdata[15:0] = ctrl & ~(16'h0001 << PTB_B_UNUSED14);
            else if (hit(addr_q, PTB_OFF_PERIOD))
               next_hrdata[15:0] = period_buf;
            else if (hit(addr_q, PTB_OFF_ACTIVE))
               next_hrdata[15:0] = active_period;
            else if (hit(addr_q, PTB_OFF_COUNT))
               next_hrdata[15:0] = count;
            else if (hit(addr_q, PTB_OFF_SEVT_CMP))
               next_hrdata[15:0] = sevt_cmp;
         end
      end
   end

   assign wr_ctrl = (state == PTB_BUS_ACC) && write_q && hit(addr_q, PTB_OFF_CTRL);
   assign wr_period = (state == PTB_BUS_ACC) && write_q && hit(addr_q, PTB_OFF_PERIOD);
   assign wr_cmp = (state == PTB_BUS_ACC) && write_q && hit(addr_q, PTB_OFF_SEVT_CMP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= PTB_BUS_IDLE;
         addr_q <= 8'h00;
         write_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         state <= next_state;
         addr_q <= next_addr_q;
         write_q <= next_write_q;
         hreadyout <= next_hreadyout;
         hrdata <= next_hrdata;
         hresp <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   logic en, idle_stop, irq_en, imm_upd, pol_inv, sout_en, ext_en;
   logic [PTB_SYNC_SRC_W-1:0] src_sel;
   logic [PTB_POSTSCALE_W-1:0] postscale;
   logic pending;

   assign en = ctrl[PTB_B_MODULE_ENABLE];
   assign idle_stop = ctrl[PTB_B_IDLE_STOP];
   assign pending = ctrl[PTB_B_SEVT_PENDING];
   assign irq_en = ctrl[PTB_B_SEVT_IRQ_EN];
   assign imm_upd = ctrl[PTB_B_IMM_UPDATE];
   assign pol_inv = ctrl[PTB_B_SYNC_POL_INV];
   assign sout_en = ctrl[PTB_B_SYNC_OUT_EN];
   assign ext_en = ctrl[PTB_B_EXT_SYNC_EN];
   assign src_sel = ctrl[PTB_F_SYNC_SRC_LO +: PTB_SYNC_SRC_W];
   assign postscale = ctrl[PTB_F_POSTSCALE_LO +: PTB_POSTSCALE_W];

   // ---------------------------------------------------------------
   // sync input: synchronised, polarity applied, edge detected
   // ---------------------------------------------------------------
   logic [SRC_N-1:0] sync_in_s;
   logic sync_lvl, sync_prev, sync_hit;

   ptb_sync #(.WIDTH(SRC_N)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_async(sync_in_pin),
      .pin_sync(sync_in_s)
   );

   assign sync_lvl = (32'(src_sel) < SRC_N) ? (sync_in_s[src_sel] ^ pol_inv) : 1'b0;
   assign sync_hit = en && ext_en && sync_lvl && !sync_prev;

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   logic tick, boundary;
   logic [PTB_POSTSCALE_W-1:0] ps_cnt, next_ps_cnt;
   logic sevt_fire;
   logic next_irq, next_sync_out, next_pwm_run;

   assign tick = en && !(idle_stop && cpu_idle);
   // the period must exceed the sync period or the counter rolls first
   assign boundary = tick && (count >= active_period);
   assign sevt_fire = tick && (count == sevt_cmp) && (ps_cnt == postscale);

   always_comb begin
      next_ctrl = ctrl;
      next_period_buf = period_buf;
      next_active_period = active_period;
      next_sevt_cmp = sevt_cmp;
      next_count = count;
      next_ps_cnt = ps_cnt;
      // control and compare writes apply live; a period write waits in period_buf for the next boundary or sync unless immediate update is set or en is low
      if (wr_ctrl)
         next_ctrl = (hwdata[15:0] & PTB_CTRL_WMASK) | (ctrl & ~PTB_CTRL_WMASK);
      if (wr_period)
         next_period_buf = hwdata[15:0];
      if (wr_cmp)
         next_sevt_cmp = hwdata[15:0];
      // hardware clears on acknowledge, but a new event wins
      if (irq_ack)
         next_ctrl[PTB_B_SEVT_PENDING] = 1'b0;
      if (sevt_fire)
         next_ctrl[PTB_B_SEVT_PENDING] = 1'b1;
      if (!en) begin
         next_count = 16'h0000;
         next_ps_cnt = '0;
         next_active_period = next_period_buf;
      end else begin
         if (sync_hit || boundary)
            next_count = 16'h0000;
         else if (tick)
            next_count = count + 16'h0001;
         if (tick && (count == sevt_cmp))
            next_ps_cnt = (ps_cnt == postscale) ? '0 : ps_cnt + 1'b1;
         if (imm_upd && wr_period)
            next_active_period = hwdata[15:0];
         else if (!imm_upd && (boundary || sync_hit))
            next_active_period = period_buf;
      end
      next_irq = next_ctrl[PTB_B_SEVT_PENDING] && irq_en;
      next_sync_out = sout_en && ((boundary || sync_hit) ^ pol_inv);
      next_pwm_run = next_ctrl[PTB_B_MODULE_ENABLE];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= PTB_CTRL_RESET;
         period_buf <= PTB_PERIOD_RESET;
         active_period <= PTB_PERIOD_RESET;
         sevt_cmp <= PTB_SEVT_CMP_RESET;
         count <= 16'h0000;
         ps_cnt <= '0;
         sync_prev <= 1'b0;
         special_event_irq <= 1'b0;
         sync_out_pin <= 1'b0;
         pwm_run <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         period_buf <= next_period_buf;
         active_period <= next_active_period;
         sevt_cmp <= next_sevt_cmp;
         count <= next_count;
         ps_cnt <= next_ps_cnt;
         sync_prev <= sync_lvl;
         special_event_irq <= next_irq;
         sync_out_pin <= next_sync_out;
         pwm_run <= next_pwm_run;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_disabled_idle: assert property (!en |=> count == 16'h0000)
      else $error("time base moved while disabled");
   chk_idle_halt: assert property (en && idle_stop && cpu_idle && !sync_hit && $stable(en) |=> $stable(count))
      else $error("time base ran in idle with idle-stop set");
   chk_idle_runs: assert property (en && !idle_stop && cpu_idle && !boundary && !sync_hit
         |=> count == $past(count) + 16'h0001)
      else $error("time base stopped in idle without idle-stop");
   chk_pending_set: assert property (sevt_fire |=> pending)
      else $error("special event did not set pending");
   chk_pending_hold: assert property (pending && !irq_ack ##1 !irq_ack |-> pending)
      else $error("pending dropped without acknowledge");
   chk_irq_gate: assert property (special_event_irq |-> pending && $past(irq_en))
      else $error("interrupt raised while disabled or idle");
   chk_imm_update: assert property (en && imm_upd && wr_period |=> active_period == $past(hwdata[15:0]))
      else $error("immediate period update missed");
   chk_defer_update: assert property (en && !imm_upd && !boundary && !sync_hit |=> $stable(active_period))
      else $error("period loaded off a cycle boundary");
   chk_sync_out_pol: assert property (sout_en && pol_inv && (boundary || sync_hit) |=> !sync_out_pin)
      else $error("sync output polarity wrong");
   chk_sync_out_off: assert property (!sout_en |=> !sync_out_pin)
      else $error("sync output driven while disabled");
   chk_sync_restart: assert property (sync_hit |=> count == 16'h0000)
      else $error("external sync did not restart time base");
   // only a control read is bound to show zero here; other registers may carry bit 14
   chk_bit14_zero: assert property (state == PTB_BUS_ACC && !write_q && addr_q == PTB_OFF_CTRL
         |=> hrdata[PTB_B_UNUSED14] == 1'b0)
      else $error("unimplemented bit read as one");
   chk_field_write: assert property (wr_ctrl && !irq_ack |=> ctrl[6:0] == $past(hwdata[6:0]))
      else $error("source or postscale field not written");

   // ---------------------------------------------------------------
   // status, interrupt, sync output, run output, counter and bit 14 checks
   // ---------------------------------------------------------------
   // a register write never moves the status bit; only an event or an acknowledge does
   chk_stat_readonly: assert property (wr_ctrl && !irq_ack && !sevt_fire |=> pending == $past(pending))
      else $error("software write changed pending");
   chk_pending_clear: assert property (irq_ack && !sevt_fire |=> !pending)
      else $error("acknowledge did not clear pending");
   chk_pending_quiet: assert property (!en |=> !$rose(pending))
      else $error("pending set while module disabled");
   chk_irq_raise: assert property (pending && irq_en && !irq_ack |=> special_event_irq)
      else $error("enabled interrupt not raised");
   chk_irq_quiet: assert property (!irq_en |=> !special_event_irq)
      else $error("interrupt raised while not enabled");
   chk_run_follow: assert property (wr_ctrl |=> pwm_run == $past(hwdata[PTB_B_MODULE_ENABLE]))
      else $error("run output does not follow module enable");
   chk_sync_out_idle: assert property (sout_en && !pol_inv && !boundary && !sync_hit |=> !sync_out_pin)
      else $error("active high sync output not idle low");
   chk_sync_out_on: assert property (sout_en && !pol_inv && (boundary || sync_hit) |=> sync_out_pin)
      else $error("enabled sync output did not pulse");
   // without external sync the counter only rolls at its own boundary
   chk_ext_off: assert property (tick && !ext_en && !boundary |=> count == $past(count) + 16'h0001)
      else $error("time base restarted with external sync off");
   chk_bit14_wr: assert property (wr_ctrl |=> ctrl[PTB_B_UNUSED14] == 1'b0)
      else $error("unimplemented bit took a write");

   cov_sync_hit: cover property (sync_hit);
   cov_irq: cover property (special_event_irq ##1 irq_ack);
   cov_imm: cover property (en && imm_upd && wr_period);
   cov_idle_halt: cover property (en && idle_stop && cpu_idle);
   cov_boundary: cover property (boundary && !imm_upd);

endmodule // ptb_ctrl
`default_nettype wire

// ==== rtl/ptb_pkg.sv ====
// shared constants of the pwm primary time base control block
// assumes a 32-bit ahb-lite register bus and one 100 MHz clock
package ptb_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] PTB_OFF_CTRL = 8'h00;
   localparam logic [7:0] PTB_OFF_PERIOD = 8'h04;
   localparam logic [7:0] PTB_OFF_ACTIVE = 8'h08;
   localparam logic [7:0] PTB_OFF_COUNT = 8'h0C;
   localparam logic [7:0] PTB_OFF_SEVT_CMP = 8'h10;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int PTB_B_MODULE_ENABLE = 15;
   localparam int PTB_B_UNUSED14 = 14;
   localparam int PTB_B_IDLE_STOP = 13;
   localparam int PTB_B_SEVT_PENDING = 12;
   localparam int PTB_B_SEVT_IRQ_EN = 11;
   localparam int PTB_B_IMM_UPDATE = 10;
   localparam int PTB_B_SYNC_POL_INV = 9;
   localparam int PTB_B_SYNC_OUT_EN = 8;
   localparam int PTB_B_EXT_SYNC_EN = 7;
   localparam int PTB_F_SYNC_SRC_LO = 4;
   localparam int PTB_F_POSTSCALE_LO = 0;
   localparam int PTB_SYNC_SRC_W = 3;
   localparam int PTB_POSTSCALE_W = 4;

   // bits software may write; pending and bit 14 are not among them
   localparam logic [15:0] PTB_CTRL_WMASK = 16'hAFFF;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] PTB_CTRL_RESET = 16'h0000;
   localparam logic [15:0] PTB_PERIOD_RESET = 16'h0000;
   localparam logic [15:0] PTB_SEVT_CMP_RESET = 16'h0000;

   typedef enum logic [0:0] {
      PTB_BUS_IDLE = 1'b0,
      PTB_BUS_ACC = 1'b1
   } ptb_bus_e;

endpackage

// ==== rtl/ptb_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins are quasi-static levels or pulses longer than two clocks
`timescale 1ns/1ns
`default_nettype none
module ptb_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pins and their synchronised copies
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] stage1;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               stage1[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
            end else begin
               stage1[gi] <= pin_async[gi];
               pin_sync[gi] <= stage1[gi];
            end
         end
      end
   endgenerate
endmodule // ptb_sync
`default_nettype wire

// ==== sim/ptb_sync_model.sv ====
// model of the external sync source and of the sync output receiver
// assumes the bench sets pol to the polarity programmed in the block
`timescale 1ns/1ns
`default_nettype none
module ptb_sync_model (
   // clock and polarity
   input wire logic hclk,
   input wire logic pol,
   // pins
   output logic [7:0] sync_in_pin,
   input wire logic sync_out_pin
);
   logic [7:0] act = 8'h00;
   int out_pulses = 0;

   // ---------------------------------------------------------------
   // source side
   // ---------------------------------------------------------------
   // idle sources sit at their inactive level for the chosen polarity
   assign sync_in_pin = act ^ {8{pol}};

   // four cycles each way, well clear of the two-cycle minimum
   task automatic pulse(input int idx);
      @(posedge hclk);
      act[idx] <= 1'b1;
      repeat (4) @(posedge hclk);
      act[idx] <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask

   // ---------------------------------------------------------------
   // receiver side
   // ---------------------------------------------------------------
   always @(posedge hclk) begin
      if (sync_out_pin !== pol) out_pulses <= out_pulses + 1;
   end
endmodule // ptb_sync_model
`default_nettype wire

// ==== sim/tb_pwm_primary_time_base_control.sv ====
// self-checking bench of the pwm time base control block
// assumes one 100 MHz clock and the sync model beside the block
`timescale 1ns/1ns
`default_nettype none
module tb_pwm_primary_time_base_control
   import ptb_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic cpu_idle = 1'b0;
   logic irq_ack = 1'b0;
   logic pol = 1'b0;
   logic hreadyout, hresp, special_event_irq, pwm_run, sync_out_pin;
   logic [31:0] hrdata, rd, rd2;
   logic [7:0] sync_in_pin;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   int p0;
   // address, write data, read-back value
   localparam logic [39:0] ROWS [8] = '{40'h007FFF2FFF, 40'h0000700070, 40'h00000F000F, 40'h0000000000,
      40'h0412341234, 40'h0855551234, 40'h1000AB00AB, 40'h40FFFF0000};
   // control value, cpu idle, count moving
   localparam logic [17:0] RUNS [4] = '{{16'h0000, 2'h0}, {16'hA000, 2'h2}, {16'hA000, 2'h1}, {16'h8000, 2'h3}};
   // control value, polarity, expected sync output pulses
   localparam logic [18:0] SYNCS [3] = '{{16'h81A0, 3'h1}, {16'h83A0, 3'h5}, {16'h80A0, 3'h0}};

   always #5 hclk = ~hclk;

   ptb_ctrl #(.SRC_N(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cpu_idle(cpu_idle), .irq_ack(irq_ack), .special_event_irq(special_event_irq),
      .pwm_run(pwm_run), .sync_in_pin(sync_in_pin), .sync_out_pin(sync_out_pin));

   ptb_sync_model u_sm (.hclk(hclk), .pol(pol), .sync_in_pin(sync_in_pin), .sync_out_pin(sync_out_pin));

   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] wd, output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] wd);
      bus(1'b1, a, wd, rd2);
   endtask
   task automatic rdw(input logic [7:0] a);
      bus(1'b0, a, 16'h0, rd);
   endtask
   task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_b(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // a hang is cut off far beyond the several hundred cycles the run needs
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge hclk);
      cmp_b(pwm_run | special_event_irq | sync_out_pin, 1'b0);
      hresetn <= 1'b1;
      rdw(8'h00);
      cmp_w(rd[15:0], 16'h0000);
      foreach (ROWS[i]) begin
         wr(ROWS[i][39:32], ROWS[i][31:16]);
         rdw(ROWS[i][39:32]);
         cmp_w(rd[15:0], ROWS[i][15:0]);
         cmp_w(rd[31:16], 16'h0000);
         cmp_b(hresp, 1'b0);
      end
      $display("test registers done");
      wr(8'h04, 16'h00FF);
      foreach (RUNS[i]) begin
         cpu_idle <= RUNS[i][1];
         wr(8'h00, RUNS[i][17:2]);
         rdw(8'h0C);
         p0 = rd;
         rdw(8'h0C);
         cmp_b(rd !== p0, RUNS[i][0]);
         cmp_b(pwm_run, RUNS[i][17]);
      end
      cpu_idle <= 1'b0;
      $display("test run and idle done");
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0010);
      wr(8'h10, 16'h0005);
      wr(8'h00, 16'h8000);
      repeat (40) @(posedge hclk);
      cmp_b(special_event_irq, 1'b0);
      rdw(8'h00);
      cmp_w(rd[15:0], 16'h9000);
      wr(8'h00, 16'h8800);
      repeat (2) @(posedge hclk);
      cmp_b(special_event_irq, 1'b1);
      wr(8'h00, 16'h0800);
      wr(8'h10, 16'h00FF);
      irq_ack <= 1'b1;
      @(posedge hclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge hclk);
      cmp_b(special_event_irq, 1'b0);
      rdw(8'h00);
      cmp_w(rd[15:0], 16'h0800);
      $display("test special event done");
      // period well above the single sync interval used here
      wr(8'h04, 16'h00FF);
      foreach (SYNCS[i]) begin
         wr(8'h00, SYNCS[i][18:3] & 16'h7FFF);
         pol <= SYNCS[i][2];
         wr(8'h00, SYNCS[i][18:3]);
         repeat (40) @(posedge hclk);
         cmp_b(sync_out_pin, SYNCS[i][2] & SYNCS[i][11]);
         p0 = u_sm.out_pulses;
         u_sm.pulse(2);
         rdw(8'h0C);
         cmp_b(rd[15:0] < 16'h0014, 1'b1);
         cmp_w(16'(u_sm.out_pulses - p0), {14'h0, SYNCS[i][1:0]});
      end
      $display("test sync done");
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      cmp_b(pwm_run | sync_out_pin, 1'b0);
      hresetn <= 1'b1;
      rdw(8'h00);
      cmp_w(rd[15:0], 16'h0000);
      $display("test second reset done");
      wr(8'h04, 16'h0080);
      wr(8'h00, 16'h8000);
      wr(8'h04, 16'h00F0);
      rdw(8'h08);
      cmp_w(rd[15:0], 16'h0080);
      // one full period of 129 cycles brings the boundary load
      repeat (140) @(posedge hclk);
      rdw(8'h08);
      cmp_w(rd[15:0], 16'h00F0);
      wr(8'h00, 16'h0400);
      wr(8'h00, 16'h8400);
      wr(8'h04, 16'h0040);
      rdw(8'h08);
      cmp_w(rd[15:0], 16'h0040);
      $display("test period update done");
      end_of_test();
   end
endmodule // tb_pwm_primary_time_base_control
`default_nettype wire
